// >>> verilog/core_dbg_pkg.sv
// Constants and types shared by the debug and test-access port
// Operation
// - comms_rx_full is high while unread receive data waits
// - comms_tx_empty is high while the transmit buffer is empty
// - debug_ack is high exactly while the core is in debug state
// - data_watch_in high at end of a data request enters debug state
// - two-bit ext_cond_in qualifies watchpoint matches
// - instr_break_in on a fetch halts when that instruction reaches Execute
// - instr_exec_flag marks an instruction in Execute that really executed
// - watch_match_out shows each watchpoint match, enabled or not
// - internal_halt_req combines external_halt_req with control bit 1
// - external_halt_req forces debug state
// - tap_instr_view shows the instruction register, changed in UPDATE-IR
// - debug_logic_reset_n asynchronously clears the debug logic
// - serial_out_drive_n is low while test_data_out shifts data
// - chain_select_view shows the scan chain, changed in UPDATE-DR
// - ext_chain_serial_out carries data into the external chain
// - tap_state_view always shows the TAP controller state
// - test_clock_enable steps the TAP; tms steers, tdi in, tdo out
// - everything runs on the rising edge of the single core clock
package core_dbg_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_DCTRL, SEL_DSTAT, SEL_TX, SEL_RX,
    SEL_WP0_ADDR, SEL_WP0_MASK, SEL_WP1_ADDR, SEL_WP1_MASK, SEL_WP_CTRL
  } reg_sel_t;

  // Register byte addresses
  localparam logic [11:0] OFF_DCTRL = 12'h000;
  localparam logic [11:0] OFF_DSTAT = 12'h004;
  localparam logic [11:0] OFF_TX = 12'h008;
  localparam logic [11:0] OFF_RX = 12'h00c;
  localparam logic [11:0] OFF_WP0_ADDR = 12'h010;
  localparam logic [11:0] OFF_WP0_MASK = 12'h014;
  localparam logic [11:0] OFF_WP1_ADDR = 12'h018;
  localparam logic [11:0] OFF_WP1_MASK = 12'h01c;
  localparam logic [11:0] OFF_WP_CTRL = 12'h020;

  // Field positions
  localparam int DCTRL_RESTART = 0;
  localparam int DCTRL_HALT = 1;
  localparam int WPC_EXT_LSB = 2;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_IR = 4'he;
  localparam logic [4:0] RST_CHAIN = 5'h00;

  // TAP instructions and chains
  localparam logic [3:0] IR_SCAN_N = 4'h2;
  localparam logic [3:0] IR_RESTART = 4'h4;
  localparam logic [3:0] IR_INTEST = 4'hc;
  localparam logic [3:0] IR_IDCODE = 4'he;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [4:0] CHAIN_COMMS = 5'h02;

  // Data register lengths and synchroniser width
  localparam int LEN_BYPASS = 1;
  localparam int LEN_SCAN_N = 5;
  localparam int LEN_IDCODE = 32;
  localparam int LEN_COMMS = 33;
  localparam int N_PINS = 10;

endpackage : core_dbg_pkg

// >>> verilog/tap_fsm.sv
// Sixteen-state test access port controller
`timescale 1ns/1ps
`default_nettype none
module tap_fsm
  import core_dbg_pkg::*;
(
  input wire logic pclk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic tms,
  output var tap_state_t state
);

  typedef struct packed {
    tap_state_t st;
  } tap_regs_t;

  tap_regs_t r;
  tap_regs_t next_r;

  assign state = r.st;

  always_comb begin
    next_r = r;
    if (step) begin
      case (r.st)
        TAP_RESET: next_r.st = tms ? TAP_RESET : TAP_IDLE;
        TAP_IDLE: next_r.st = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: next_r.st = tms ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: next_r.st = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: next_r.st = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: next_r.st = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: next_r.st = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: next_r.st = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
        TAP_UPD_DR: next_r.st = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR: next_r.st = tms ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR: next_r.st = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: next_r.st = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: next_r.st = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: next_r.st = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: next_r.st = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
        TAP_UPD_IR: next_r.st = tms ? TAP_SEL_DR : TAP_IDLE;
        default: next_r.st = TAP_RESET;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      r.st <= TAP_RESET;
    end else begin
      r <= next_r;
    end
  end

endmodule : tap_fsm
`default_nettype wire

// >>> verilog/core_debug_tap_port.sv
// Debug state control, watchpoints, comms channel and TAP data path
`timescale 1ns/1ps
`default_nettype none
module core_debug_tap_port
  import core_dbg_pkg::*;
#(
  // Arbitrary identification value
  parameter logic [31:0] ID_VALUE = 32'h1234_5671
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic data_req_done,
  input wire logic [31:0] data_addr,
  input wire logic fetch_done,
  input wire logic pipe_advance,
  input wire logic exec_pass,
  input wire logic debug_enable_in,
  input wire logic data_watch_in,
  input wire logic instr_break_in,
  input wire logic external_halt_req,
  input wire logic [1:0] ext_cond_in,
  input wire logic debug_logic_reset_n,
  input wire logic test_clock_enable,
  input wire logic test_mode_select,
  input wire logic test_data_in,
  input wire logic ext_chain_serial_in,
  output logic comms_rx_full,
  output logic comms_tx_empty,
  output logic debug_ack,
  output logic instr_exec_flag,
  output logic [1:0] watch_match_out,
  output logic internal_halt_req,
  output logic [3:0] tap_instr_view,
  output logic serial_out_drive_n,
  output logic [4:0] chain_select_view,
  output logic ext_chain_serial_out,
  output logic [3:0] tap_state_view,
  output logic test_data_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [N_PINS-1:0] s1;
    logic [N_PINS-1:0] s2;
    logic [3:0] cd1;
    logic [3:0] cd2;
    logic [1:0] brk_pipe;
    logic ack;
    logic halt_out;
    logic exec_flag;
    logic [1:0] wmatch;
    logic rdy;
    logic err;
    logic [31:0] rdata;
    logic halt_bit;
    logic [31:0] tx_data;
    logic [31:0] rx_data;
    logic tx_empty;
    logic rx_full;
    logic [1:0][31:0] wp_addr;
    logic [1:0][31:0] wp_mask;
    logic [1:0] wp_en;
    logic [1:0] wp_ext;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic [32:0] dr;
    logic [4:0] chain;
    logic tdo;
    logic drive_n;
    logic sd_out;
  } dbg_regs_t;

  dbg_regs_t r;
  dbg_regs_t next_r;
  tap_state_t tap_state;
  logic rst_n;

  // debug reset joins the bus reset
  assign rst_n = presetn & debug_logic_reset_n;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic reg_sel_t sel_of(input logic [11:0] a);
    case (a)
      OFF_DCTRL: sel_of = SEL_DCTRL;
      OFF_DSTAT: sel_of = SEL_DSTAT;
      OFF_TX: sel_of = SEL_TX;
      OFF_RX: sel_of = SEL_RX;
      OFF_WP0_ADDR: sel_of = SEL_WP0_ADDR;
      OFF_WP0_MASK: sel_of = SEL_WP0_MASK;
      OFF_WP1_ADDR: sel_of = SEL_WP1_ADDR;
      OFF_WP1_MASK: sel_of = SEL_WP1_MASK;
      OFF_WP_CTRL: sel_of = SEL_WP_CTRL;
      default: sel_of = SEL_NONE;
    endcase
  endfunction : sel_of

  function automatic int dr_len(input logic [3:0] ir);
    case (ir)
      IR_BYPASS: dr_len = LEN_BYPASS;
      IR_SCAN_N: dr_len = LEN_SCAN_N;
      IR_IDCODE: dr_len = LEN_IDCODE;
      default: dr_len = LEN_COMMS;
    endcase
  endfunction : dr_len

  // Bit entering at the top of a register of the given length
  function automatic logic [32:0] shift_in(input logic [32:0] d, input int len, input logic b);
    logic [32:0] s;
    s = d >> 1;
    s[len-1] = b;
    shift_in = s;
  endfunction : shift_in

  tap_fsm u_tap (
    .pclk(pclk),
    .rst_n(rst_n),
    .step(r.s2[6]),
    .tms(r.s2[7]),
    .state(tap_state)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = r.rdata;
  assign pready = r.rdy;
  assign pslverr = r.err;
  assign comms_rx_full = r.rx_full;
  assign comms_tx_empty = r.tx_empty;
  assign debug_ack = r.ack;
  assign instr_exec_flag = r.exec_flag;
  assign watch_match_out = r.wmatch;
  assign internal_halt_req = r.halt_out;
  assign tap_instr_view = r.ir;
  assign serial_out_drive_n = r.drive_n;
  assign chain_select_view = r.chain;
  assign ext_chain_serial_out = r.sd_out;
  assign tap_state_view = 4'(tap_state);
  assign test_data_out = r.tdo;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic dbg_en;
    logic watch_s;
    logic brk_s;
    logic halt_s;
    logic step;
    logic tdi;
    logic ext_s;
    logic [1:0] cond_s;
    logic [1:0] m;
    logic req;
    logic int_hit;
    logic ext_hit;
    logic brk_new;
    logic enter;
    logic restart;
    logic ext_sel;
    logic setup;
    logic acc;
    reg_sel_t sel;
    dbg_en = r.s2[9];
    watch_s = r.s2[8];
    brk_s = r.s2[5];
    halt_s = r.s2[4];
    cond_s = r.s2[3:2];
    step = r.s2[6];
    tdi = r.s2[1];
    ext_s = r.s2[0];
    m = '0;
    restart = 1'b0;
    next_r = r;

    // Pins pass two flops; core strobes are delayed to stay aligned
    next_r.s1 = {debug_enable_in, data_watch_in, test_mode_select, test_clock_enable,
                 instr_break_in, external_halt_req, ext_cond_in, test_data_in, ext_chain_serial_in};
    next_r.s2 = r.s1;
    next_r.cd1 = {data_req_done, fetch_done, pipe_advance, exec_pass};
    next_r.cd2 = r.cd1;

    // ************************************************************
    // Watchpoints
    // ************************************************************
    for (int i = 0; i < 2; i++) begin
      m[i] = ((data_addr & ~r.wp_mask[i]) == (r.wp_addr[i] & ~r.wp_mask[i]))
             && (!r.wp_ext[i] || cond_s[i]);
    end
    next_r.wmatch = m;
    int_hit = data_req_done && |(m & r.wp_en);
    // data watch at end of data request
    ext_hit = r.cd2[3] && watch_s;

    // ************************************************************
    // Breakpoint pipeline
    // ************************************************************
    // tag follows the fetched instruction
    brk_new = r.cd2[2] && brk_s;
    if (r.cd2[1]) begin
      next_r.brk_pipe = {r.brk_pipe[0], brk_new};
    end else if (r.cd2[2]) begin
      next_r.brk_pipe[0] = brk_new;
    end

    // ************************************************************
    // Debug state
    // ************************************************************
    // combined halt request
    req = halt_s || r.halt_bit;
    next_r.halt_out = req;
    enter = dbg_en && !r.ack && (req || ext_hit || int_hit || r.brk_pipe[1]);
    // breakpointed or halted instructions do not count
    next_r.exec_flag = r.cd2[0] && !r.ack && !r.brk_pipe[1];
    if (r.brk_pipe[1]) begin
      next_r.brk_pipe[1] = 1'b0;
    end

    // ************************************************************
    // APB slave, zero wait states
    // ************************************************************
    setup = psel && !penable;
    acc = psel && penable && r.rdy;
    sel = sel_of(paddr);
    next_r.rdy = setup;
    next_r.err = setup && (sel == SEL_NONE);
    if (setup) begin
      case (sel)
        SEL_DCTRL: next_r.rdata = 32'(r.halt_bit) << DCTRL_HALT;
        SEL_DSTAT: next_r.rdata = {24'h000000, dbg_en, 4'(tap_state), r.tx_empty, r.rx_full, r.ack};
        SEL_TX: next_r.rdata = r.tx_data;
        SEL_RX: next_r.rdata = r.rx_data;
        SEL_WP0_ADDR: next_r.rdata = r.wp_addr[0];
        SEL_WP0_MASK: next_r.rdata = r.wp_mask[0];
        SEL_WP1_ADDR: next_r.rdata = r.wp_addr[1];
        SEL_WP1_MASK: next_r.rdata = r.wp_mask[1];
        SEL_WP_CTRL: next_r.rdata = {28'h0000000, r.wp_ext, r.wp_en};
        default: next_r.rdata = RST_WORD;
      endcase
    end
    if (acc && pwrite) begin
      case (sel)
        SEL_DCTRL: begin
          next_r.halt_bit = pwdata[DCTRL_HALT];
          restart = pwdata[DCTRL_RESTART];
        end
        SEL_TX: begin
          next_r.tx_data = pwdata;
        end
        SEL_WP0_ADDR: next_r.wp_addr[0] = pwdata;
        SEL_WP0_MASK: next_r.wp_mask[0] = pwdata;
        SEL_WP1_ADDR: next_r.wp_addr[1] = pwdata;
        SEL_WP1_MASK: next_r.wp_mask[1] = pwdata;
        SEL_WP_CTRL: begin
          next_r.wp_en = pwdata[1:0];
          next_r.wp_ext = pwdata[WPC_EXT_LSB+1:WPC_EXT_LSB];
        end
        default: begin
        end
      endcase
    end
    // reading receive data frees the buffer
    if (acc && !pwrite && sel == SEL_RX) begin
      next_r.rx_full = 1'b0;
    end

    // ************************************************************
    // TAP data path
    // ************************************************************
    ext_sel = (r.ir == IR_INTEST) && (r.chain != CHAIN_COMMS);
    next_r.drive_n = !(tap_state == TAP_SHIFT_DR || tap_state == TAP_SHIFT_IR);
    if (tap_state == TAP_SHIFT_IR) begin
      next_r.tdo = r.ir_sh[0];
    end else if (tap_state == TAP_SHIFT_DR) begin
      next_r.tdo = ext_sel ? ext_s : r.dr[0];
    end
    if (tap_state == TAP_RESET) begin
      next_r.ir = RST_IR;
    end
    // TAP advances only on enabled edges
    if (step) begin
      case (tap_state)
        TAP_IDLE: begin
          if (r.ir == IR_RESTART) begin
            restart = 1'b1;
          end
        end
        TAP_CAP_IR: next_r.ir_sh = IR_CAPTURE;
        TAP_SHIFT_IR: next_r.ir_sh = {tdi, r.ir_sh[3:1]};
        TAP_UPD_IR: next_r.ir = r.ir_sh;
        TAP_CAP_DR: begin
          case (r.ir)
            IR_SCAN_N: next_r.dr = {28'h0000000, r.chain};
            IR_IDCODE: next_r.dr = {1'b0, ID_VALUE};
            IR_INTEST: begin
              next_r.dr = {!r.tx_empty, r.tx_data};
              if (r.chain == CHAIN_COMMS) begin
                next_r.tx_empty = 1'b1;
              end
            end
            default: next_r.dr = '0;
          endcase
        end
        TAP_SHIFT_DR: begin
          next_r.dr = shift_in(r.dr, dr_len(r.ir), tdi);
          if (ext_sel) begin
            next_r.sd_out = tdi;
          end
        end
        TAP_UPD_DR: begin
          if (r.ir == IR_SCAN_N) begin
            next_r.chain = r.dr[4:0];
          end
          // new word from the debugger, set wins over read
          if (r.ir == IR_INTEST && r.chain == CHAIN_COMMS && r.dr[32]) begin
            next_r.rx_data = r.dr[31:0];
            next_r.rx_full = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // a core write refills the buffer; it wins so no word is lost
    if (acc && pwrite && sel == SEL_TX) begin
      next_r.tx_empty = 1'b0;
    end

    // acknowledge tracks debug state; entry beats restart
    if (enter) begin
      next_r.ack = 1'b1;
    end else if (restart) begin
      next_r.ack = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.tx_empty <= 1'b1;
      r.ir <= RST_IR;
      r.ir_sh <= RST_IR;
      r.chain <= RST_CHAIN;
      r.drive_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

endmodule : core_debug_tap_port
`default_nettype wire

// >>> bench/core_debug_tap_port_chk.sv
// Concurrent checks on the ports of the debug and test-access port
`timescale 1ns/1ps
`default_nettype none
module core_debug_tap_port_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic debug_logic_reset_n,
  input wire logic debug_enable_in,
  input wire logic external_halt_req,
  input wire logic internal_halt_req,
  input wire logic debug_ack,
  input wire logic instr_exec_flag,
  input wire logic test_clock_enable,
  input wire logic test_mode_select,
  input wire logic serial_out_drive_n,
  input wire logic [3:0] tap_state_view,
  input wire logic [3:0] tap_instr_view,
  input wire logic [4:0] chain_select_view
);
  // ************************************************************
  // Properties
  // ************************************************************
  // Pins pass two sync flops, so antecedents span a few cycles
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !debug_logic_reset_n);
  a_halt_follows: assert property (external_halt_req [*4] |-> internal_halt_req)
    else $error("halt request not forwarded");
  a_halt_enters: assert property (debug_enable_in [*6] ##0 internal_halt_req |-> ##[0:3] debug_ack)
    else $error("halt request did not enter debug state");
  a_no_enable: assert property (!debug_enable_in [*8] |-> !$rose(debug_ack))
    else $error("debug entry while disabled");
  a_exec_quiet: assert property (debug_ack [*3] |-> !instr_exec_flag)
    else $error("execute flag while halted");
  a_drive_shift: assert property ($stable(tap_state_view) [*2]
    |-> serial_out_drive_n == !(tap_state_view == 4'h4 || tap_state_view == 4'hb))
    else $error("output enable does not match shift state");
  a_step_gate: assert property (!test_clock_enable [*3] |=> $stable(tap_state_view))
    else $error("TAP moved without clock enable");
  a_tms_reset: assert property ((test_clock_enable && test_mode_select) [*8]
    |-> tap_state_view == 4'h0)
    else $error("five mode-select steps did not reset the TAP");
  a_ir_update: assert property (!$stable(tap_instr_view) |-> (tap_state_view inside {4'h0, 4'hf})
    || ($past(tap_state_view) inside {4'h0, 4'hf}))
    else $error("instruction view changed outside update");
  a_chain_update: assert property (!$stable(chain_select_view) |-> (tap_state_view inside {4'h0, 4'h8})
    || ($past(tap_state_view) inside {4'h0, 4'h8}))
    else $error("chain view changed outside update");
endmodule : core_debug_tap_port_chk

bind core_debug_tap_port core_debug_tap_port_chk chk (.pclk, .presetn, .debug_logic_reset_n,
  .debug_enable_in, .external_halt_req, .internal_halt_req, .debug_ack, .instr_exec_flag,
  .test_clock_enable, .test_mode_select, .serial_out_drive_n, .tap_state_view, .tap_instr_view,
  .chain_select_view);
`default_nettype wire

// >>> bench/dbg_host_model.sv
// Test-port host and one-stage external scan chain
`timescale 1ns/1ps
`default_nettype none
module dbg_host_model (
  input wire logic pclk,
  input wire logic tdo,
  input wire logic chain_out,
  output logic tck_en = 1'b0,
  output logic tms = 1'b1,
  output logic tdi = 1'b0,
  output logic chain_in = 1'b0
);
  // ************************************************************
  // Host steps
  // ************************************************************
  // one enable pulse per step, spaced so tdo settles
  task automatic step(input logic m, input logic d);
    @(posedge pclk);
    tck_en <= 1'b1;
    tms <= m;
    tdi <= d;
    @(posedge pclk);
    tck_en <= 1'b0;
    tdi <= ~d;
    repeat (4) @(posedge pclk);
  endtask : step
  // eight enabled steps with mode select high
  task automatic reset_tap();
    @(posedge pclk);
    tck_en <= 1'b1;
    tms <= 1'b1;
    repeat (8) @(posedge pclk);
    tck_en <= 1'b0;
    repeat (4) @(posedge pclk);
    step(1'b0, 1'b0);
  endtask : reset_tap
  // from idle through shift, LSB first, back to idle
  task automatic scan(input logic ir, input int n, input logic [32:0] din, output logic [32:0] dout);
    step(1'b1, 1'b0);
    if (ir) step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      dout[i] = tdo;
      step(i == n - 1, din[i]);
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : scan
  // external chain hands its stage back on each step
  always @(posedge pclk) begin
    if (tck_en) chain_in <= chain_out;
  end
endmodule : dbg_host_model
`default_nettype wire

// >>> bench/core_debug_tap_port_tb_top.sv
// Self-checking bench for the debug and test-access port
`timescale 1ns/1ps
`default_nettype none
module core_debug_tap_port_tb_top;
  import core_dbg_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er;} row_t;
  logic pclk = 1'b0, presetn = 1'b0, debug_logic_reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, data_addr = 32'h0, prdata, rd;
  logic data_req_done = 1'b0, fetch_done = 1'b0, pipe_advance = 1'b0, exec_pass = 1'b0;
  logic debug_enable_in = 1'b0, data_watch_in = 1'b0, instr_break_in = 1'b0, external_halt_req = 1'b0;
  logic [1:0] ext_cond_in = 2'h0, watch_match_out;
  logic pready, pslverr, comms_rx_full, comms_tx_empty, debug_ack, instr_exec_flag, internal_halt_req;
  logic serial_out_drive_n, ext_chain_serial_out, test_data_out, er;
  logic test_clock_enable, test_mode_select, test_data_in, ext_chain_serial_in;
  logic [3:0] tap_instr_view, tap_state_view;
  logic [4:0] chain_select_view;
  logic [32:0] d;
  int err_count = 0, n_checks = 0;
  row_t rows[7] = '{'{1'b0, OFF_DCTRL, 32'h0, 32'h0, 1'b0}, '{1'b0, OFF_DSTAT, 32'h0, 32'h4, 1'b0},
    '{1'b1, OFF_WP0_ADDR, 32'h100, 32'h0, 1'b0}, '{1'b0, OFF_WP0_ADDR, 32'h0, 32'h100, 1'b0},
    '{1'b1, OFF_DCTRL, 32'h3, 32'h0, 1'b0}, '{1'b0, OFF_DCTRL, 32'h0, 32'h2, 1'b0},
    '{1'b0, 12'h024, 32'h0, 32'h0, 1'b1}};

  core_debug_tap_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .data_req_done, .data_addr, .fetch_done, .pipe_advance, .exec_pass, .debug_enable_in,
    .data_watch_in, .instr_break_in, .external_halt_req, .ext_cond_in, .debug_logic_reset_n,
    .test_clock_enable, .test_mode_select, .test_data_in, .ext_chain_serial_in, .comms_rx_full,
    .comms_tx_empty, .debug_ack, .instr_exec_flag, .watch_match_out, .internal_halt_req, .tap_instr_view,
    .serial_out_drive_n, .chain_select_view, .ext_chain_serial_out, .tap_state_view, .test_data_out);
  dbg_host_model host (.pclk(pclk), .tdo(test_data_out), .chain_out(ext_chain_serial_out),
    .tck_en(test_clock_enable), .tms(test_mode_select), .tdi(test_data_in), .chain_in(ext_chain_serial_in));

  always #2 pclk = ~pclk;

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  // Holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(n < 20, 1'b1);
  endtask : apb
  function automatic logic obs(input int k);
    case (k)
      0: return debug_ack;
      1: return instr_exec_flag;
      default: return internal_halt_req;
    endcase
  endfunction : obs
  task automatic await(input int k, input logic v);
    int n;
    n = 0;
    while (obs(k) !== v && n < 12) begin
      @(posedge pclk);
      n++;
    end
    check(obs(k), v);
  endtask : await
  task automatic pulse(input int k);
    {data_req_done, fetch_done, pipe_advance, exec_pass} <= 4'h8 >> k;
    @(posedge pclk);
    {data_req_done, fetch_done, pipe_advance, exec_pass} <= 4'h0;
    repeat (8) @(posedge pclk);
  endtask : pulse

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    debug_logic_reset_n <= 1'b1;
    @(posedge pclk);
    check(tap_instr_view, RST_IR);
    check(comms_tx_empty, 1'b1);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      check(er, rows[i].er);
      if (!rows[i].w) check(rd, rows[i].e);
    end
    await(2, 1'b1);
    check(debug_ack, 1'b0);
    apb(1'b1, OFF_DCTRL, 32'h0);
    await(2, 1'b0);
    debug_enable_in <= 1'b1;
    external_halt_req <= 1'b1;
    await(0, 1'b1);
    check(internal_halt_req, 1'b1);
    external_halt_req <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, OFF_DCTRL, 32'h1);
    await(0, 1'b0);
    data_watch_in <= 1'b1;
    pulse(0);
    check(debug_ack, 1'b1);
    data_watch_in <= 1'b0;
    apb(1'b1, OFF_DCTRL, 32'h1);
    await(0, 1'b0);
    apb(1'b1, OFF_WP1_ADDR, 32'h200);
    data_addr <= 32'h200;
    pulse(0);
    check(watch_match_out, 2'b10);
    check(debug_ack, 1'b0);
    apb(1'b1, OFF_WP_CTRL, 32'ha);
    pulse(0);
    check(debug_ack, 1'b0);
    ext_cond_in <= 2'b11;
    repeat (4) @(posedge pclk);
    pulse(0);
    check(debug_ack, 1'b1);
    apb(1'b1, OFF_DCTRL, 32'h1);
    await(0, 1'b0);
    exec_pass <= 1'b1;
    @(posedge pclk);
    exec_pass <= 1'b0;
    await(1, 1'b1);
    apb(1'b1, OFF_TX, 32'hcafe_0123);
    @(posedge pclk);
    check(comms_tx_empty, 1'b0);
    host.reset_tap();
    check(tap_state_view, 4'h1);
    host.scan(1'b1, 4, 33'(IR_SCAN_N), d);
    check(d[3:0], IR_CAPTURE);
    check(tap_instr_view, IR_SCAN_N);
    host.scan(1'b0, 5, 33'(CHAIN_COMMS), d);
    check(chain_select_view, CHAIN_COMMS);
    host.scan(1'b1, 4, 33'(IR_INTEST), d);
    host.scan(1'b0, 33, {1'b1, 32'h5a5a_0f0f}, d);
    check(d, {1'b1, 32'hcafe_0123});
    check(comms_tx_empty, 1'b1);
    check(comms_rx_full, 1'b1);
    apb(1'b0, OFF_RX, 32'h0);
    check(rd, 32'h5a5a_0f0f);
    @(posedge pclk);
    check(comms_rx_full, 1'b0);
    host.scan(1'b1, 4, 33'(IR_SCAN_N), d);
    host.scan(1'b0, 5, 33'h03, d);
    check(d[4:0], CHAIN_COMMS);
    check(chain_select_view, 5'h03);
    host.scan(1'b1, 4, 33'(IR_INTEST), d);
    host.scan(1'b0, 2, 33'h2, d);
    check(ext_chain_serial_out, 1'b1);
    instr_break_in <= 1'b1;
    pulse(1);
    instr_break_in <= 1'b0;
    check(debug_ack, 1'b0);
    pulse(2);
    check(debug_ack, 1'b1);
    host.scan(1'b1, 4, 33'(IR_RESTART), d);
    check(tap_instr_view, IR_RESTART);
    host.step(1'b0, 1'b0);
    await(0, 1'b0);
    apb(1'b1, OFF_DCTRL, 32'h2);
    await(0, 1'b1);
    debug_logic_reset_n <= 1'b0;
    #1;
    check(debug_ack, 1'b0);
    check(internal_halt_req, 1'b0);
    check(chain_select_view, RST_CHAIN);
    check(tap_instr_view, RST_IR);
    finish_test();
  end

  initial begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule : core_debug_tap_port_tb_top
`default_nettype wire
